// ==== hw/cspc_pkg.sv ====
package cspc_pkg;

   // Bus address of this device; the value is arbitrary.
   localparam logic [6:0] SLAVE_ADDR      = 7'h69;

   // Byte offsets reached through the command code.
   localparam logic [6:0] OFS_SERIAL_STOP = 7'h03;
   localparam logic [6:0] OFS_STRAP_FIXED = 7'h04;
   localparam logic [6:0] OFS_DRIVE_MODE  = 7'h05;
   localparam logic [6:0] OFS_TEST_STOP   = 7'h06;

   // Command code bit that selects a byte transfer over a block one.
   localparam int         CMD_BYTE_BIT    = 7;
   // Byte count sent first in a block read.
   localparam logic [7:0] BLOCK_COUNT     = 8'h07;

   // Field positions.
   localparam int B4_STRAP_E   = 7;
   localparam int B4_DOT_PD    = 6;
   localparam int B4_FIXED_HI  = 5;
   localparam int B4_FIXED_LO  = 3;
   localparam int B5_SRC_STOP  = 7;
   localparam int B5_SRC_PD    = 3;
   localparam int B5_CPU_HI    = 1;
   localparam int B6_TEST_SEL  = 7;
   localparam int B6_TEST_MODE = 6;
   localparam int B6_STRAP_D   = 5;
   localparam int B6_REF_LOW   = 4;
   localparam int B6_SW_RUN    = 3;
   localparam int B6_STRAP_HI  = 2;

   // Reset values.
   localparam logic [6:0] RST_SERIAL_STOP = 7'h00;
   localparam logic [2:0] RST_FIXED_STOP  = 3'h0;
   localparam logic [2:0] B4_RESERVED     = 3'h7;
   localparam logic       RST_REF_LOW     = 1'b1;
   localparam logic       RST_SW_RUN      = 1'b1;

   // Output clock dividers in mclk cycles, and the bus bit count per byte.
   localparam logic [3:0] DIV_LAST        = 4'hB;
   localparam logic [3:0] BUS_HIGH_FROM   = 4'h6;
   localparam logic [3:0] TEST_HALF_LAST  = 4'h3;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_CMD   = 3'b010,
      ST_COUNT = 3'b011,
      ST_WDATA = 3'b100,
      ST_RDATA = 3'b101,
      ST_SKIP  = 3'b110
   } cspc_state_t;

endpackage

// ==== hw/cspc_sync.sv ====
module cspc_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import cspc_pkg::*;

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q      <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // A new level counts only once two stages agree on it.
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule

// ==== hw/cspc_gate.sv ====
module cspc_gate #(
   parameter int N = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic         src_level,
   input  wire logic [N-1:0] stop_req,
   output logic      [N-1:0] clk_out,
   output logic      [N-1:0] stopped
);
   import cspc_pkg::*;

   // Stop state may change only while the source is low, so an output
   // always ends on a whole low phase and restarts on a whole high one.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stopped <= '0;
      end else if (!src_level) begin
         stopped <= stop_req;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_out <= '0;
      end else begin
         clk_out <= {N{src_level}} & ~stopped;
      end
   end
endmodule

// ==== hw/cspc_top.sv ====
module cspc_top (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       scl_pin,
   input  wire logic       sda_pin_in,
   output logic            sda_pin_out,
   output logic            sda_pin_oe,
   input  wire logic       freq_strap_first,
   input  wire logic       freq_strap_second,
   input  wire logic       freq_strap_third,
   input  wire logic       freq_strap_fourth,
   input  wire logic       freq_strap_fifth,
   input  wire logic       power_good_input_n,
   input  wire logic       power_down_input,
   output logic      [7:1] serial_ref_true,
   output logic      [7:1] serial_ref_comp,
   output logic      [7:1] serial_ref_oe,
   output logic      [2:0] fixed_bus_clk,
   output logic      [2:0] fixed_bus_oe,
   output logic      [5:0] bus_clk,
   output logic      [5:0] bus_clk_oe,
   output logic            display_96mhz_oe,
   output logic      [1:0] cpu_pair_oe,
   output logic            ref_drive_low
);
   import cspc_pkg::*;

   logic [8:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        pd_s;
   logic        pg_n_s;
   logic [4:0]  strap_s;
   logic        scl_prev;
   logic        sda_prev;
   logic        pg_n_prev;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;

   cspc_state_t state_reg;
   logic [3:0]  bit_cnt_reg;
   logic        ack_phase_reg;
   logic        sda_low_reg;
   logic [7:0]  rx_reg;
   logic [7:0]  tx_reg;
   logic [6:0]  ptr_reg;
   logic        block_reg;
   logic        first_rd_reg;
   logic        nack_reg;
   logic        byte_done;
   logic        wr_en;
   logic        count_first;
   logic [7:0]  next_tx;

   logic [7:1]  serial_stop_en_reg;
   logic [2:0]  fixed_stop_en_reg;
   logic        dot_pd_tri_reg;
   logic        src_stop_tri_reg;
   logic        src_pd_tri_reg;
   logic [1:0]  cpu_pd_tri_reg;
   logic        test_sel_reg;
   logic        test_mode_reg;
   logic        ref_low_reg;
   logic        sw_run_reg;
   logic [4:0]  strap_reg;

   logic [3:0]  div_cnt_reg;
   logic [3:0]  test_cnt_reg;
   logic        test_level_reg;
   logic        test_ref_reg;
   logic        src_level;
   logic        bus_level;
   logic        stop_active;
   logic        test_tri;
   logic        test_ref;
   logic [7:1]  src_req;
   logic [7:1]  src_out;
   logic [7:1]  src_stopped;
   logic [8:0]  bus_req;
   logic [8:0]  bus_out;
   logic [8:0]  bus_stopped;

   cspc_sync #(
      .W (9)
   ) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     ({scl_pin, sda_pin_in, power_down_input, power_good_input_n,
               freq_strap_fifth, freq_strap_fourth, freq_strap_third,
               freq_strap_second, freq_strap_first}),
      .q     (pins_s)
   );

   assign scl_s   = pins_s[8];
   assign sda_s   = pins_s[7];
   assign pd_s    = pins_s[6];
   assign pg_n_s  = pins_s[5];
   assign strap_s = pins_s[4:0];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev  <= 1'b1;
         sda_prev  <= 1'b1;
         pg_n_prev <= 1'b1;
      end else begin
         scl_prev  <= scl_s;
         sda_prev  <= sda_s;
         pg_n_prev <= pg_n_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_prev;
   assign scl_fall  = ~scl_s & scl_prev;
   assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
   assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;
   assign byte_done = scl_fall & ~ack_phase_reg
                      & (bit_cnt_reg == BITS_PER_BYTE);
   assign wr_en     = byte_done & (state_reg == ST_WDATA)
                      & ~start_det & ~stop_det;
   assign count_first = first_rd_reg & block_reg;
   // A process rather than an assign, so a change to any register that
   // the function reads refreshes the byte about to be sent.
   always_comb begin
      next_tx = count_first ? BLOCK_COUNT : reg_read(ptr_reg);
   end

   function automatic logic [7:0] reg_read(input logic [6:0] ofs);
      logic [7:0] v;
      v = 8'h00;
      unique case (ofs)
         OFS_SERIAL_STOP: v = {serial_stop_en_reg, 1'b0};
         OFS_STRAP_FIXED: v = {strap_reg[4], dot_pd_tri_reg,
                               fixed_stop_en_reg, B4_RESERVED};
         OFS_DRIVE_MODE:  v = {src_stop_tri_reg, 3'h0,
                               src_pd_tri_reg, 1'b0, cpu_pd_tri_reg};
         OFS_TEST_STOP:   v = {test_sel_reg, test_mode_reg,
                               strap_reg[3], ref_low_reg, sw_run_reg,
                               strap_reg[2:0]};
         default:         v = 8'h00;
      endcase
      return v;
   endfunction

   // Straps are caught when power-good is asserted.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strap_reg <= 5'h00;
      end else if (pg_n_prev & ~pg_n_s) begin
         strap_reg <= strap_s;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         ack_phase_reg <= 1'b0;
         sda_low_reg   <= 1'b0;
         rx_reg        <= 8'h00;
         tx_reg        <= 8'h00;
         ptr_reg       <= 7'h00;
         block_reg     <= 1'b0;
         first_rd_reg  <= 1'b0;
         nack_reg      <= 1'b0;
      end else if (start_det) begin
         state_reg     <= ST_ADDR;
         bit_cnt_reg   <= 4'h0;
         ack_phase_reg <= 1'b0;
         sda_low_reg   <= 1'b0;
      end else if (stop_det) begin
         state_reg     <= ST_IDLE;
         ack_phase_reg <= 1'b0;
         sda_low_reg   <= 1'b0;
      end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
         if (scl_rise) begin
            if (!ack_phase_reg && bit_cnt_reg != BITS_PER_BYTE) begin
               rx_reg      <= {rx_reg[6:0], sda_s};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (ack_phase_reg) begin
               nack_reg <= sda_s;
            end
         end else if (byte_done) begin
            ack_phase_reg <= 1'b1;
            sda_low_reg   <= 1'b1;
            unique case (state_reg)
               ST_ADDR: begin
                  if (rx_reg[7:1] != SLAVE_ADDR) begin
                     state_reg   <= ST_SKIP;
                     sda_low_reg <= 1'b0;
                  end else if (rx_reg[0]) begin
                     state_reg    <= ST_RDATA;
                     first_rd_reg <= 1'b1;
                  end else begin
                     state_reg <= ST_CMD;
                  end
               end
               ST_CMD: begin
                  ptr_reg   <= rx_reg[6:0];
                  block_reg <= ~rx_reg[CMD_BYTE_BIT];
                  state_reg <= rx_reg[CMD_BYTE_BIT] ? ST_WDATA : ST_COUNT;
               end
               ST_COUNT: begin
                  state_reg <= ST_WDATA;
               end
               ST_WDATA: begin
                  ptr_reg <= ptr_reg + 7'h01;
               end
               ST_RDATA: begin
                  sda_low_reg <= 1'b0;
               end
               default: begin
                  state_reg   <= ST_SKIP;
                  sda_low_reg <= 1'b0;
               end
            endcase
         end else if (scl_fall && ack_phase_reg) begin
            ack_phase_reg <= 1'b0;
            bit_cnt_reg   <= 4'h0;
            sda_low_reg   <= 1'b0;
            if (state_reg == ST_RDATA) begin
               if (nack_reg && !first_rd_reg) begin
                  state_reg <= ST_SKIP;
               end else begin
                  tx_reg       <= next_tx;
                  sda_low_reg  <= ~next_tx[7];
                  first_rd_reg <= 1'b0;
                  if (!count_first) begin
                     ptr_reg <= ptr_reg + 7'h01;
                  end
               end
            end
         end else if (scl_fall && state_reg == ST_RDATA) begin
            sda_low_reg <= ~tx_reg[3'(4'h7 - bit_cnt_reg)];
         end
      end
   end

   assign sda_pin_out = 1'b0;
   assign sda_pin_oe  = sda_low_reg;

   // Reserved and strap copy bits are not stored.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         serial_stop_en_reg <= RST_SERIAL_STOP;
         fixed_stop_en_reg  <= RST_FIXED_STOP;
         dot_pd_tri_reg     <= 1'b0;
         src_stop_tri_reg   <= 1'b0;
         src_pd_tri_reg     <= 1'b0;
         cpu_pd_tri_reg     <= 2'h0;
         test_sel_reg       <= 1'b0;
         test_mode_reg      <= 1'b0;
         ref_low_reg        <= RST_REF_LOW;
         sw_run_reg         <= RST_SW_RUN;
      end else if (wr_en) begin
         unique case (ptr_reg)
            OFS_SERIAL_STOP: begin
               serial_stop_en_reg <= rx_reg[7:1];
            end
            OFS_STRAP_FIXED: begin
               dot_pd_tri_reg    <= rx_reg[B4_DOT_PD];
               fixed_stop_en_reg <= rx_reg[B4_FIXED_HI:B4_FIXED_LO];
            end
            OFS_DRIVE_MODE: begin
               src_stop_tri_reg <= rx_reg[B5_SRC_STOP];
               src_pd_tri_reg   <= rx_reg[B5_SRC_PD];
               cpu_pd_tri_reg   <= rx_reg[B5_CPU_HI:0];
            end
            OFS_TEST_STOP: begin
               test_sel_reg  <= rx_reg[B6_TEST_SEL];
               test_mode_reg <= rx_reg[B6_TEST_MODE];
               ref_low_reg   <= rx_reg[B6_REF_LOW];
               sw_run_reg    <= rx_reg[B6_SW_RUN];
            end
            default: begin
            end
         endcase
      end
   end

   // One counter times both output families so their edges line up.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= 4'h0;
      end else if (div_cnt_reg == DIV_LAST) begin
         div_cnt_reg <= 4'h0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         test_cnt_reg   <= 4'h0;
         test_level_reg <= 1'b0;
      end else if (test_cnt_reg == TEST_HALF_LAST) begin
         test_cnt_reg   <= 4'h0;
         test_level_reg <= ~test_level_reg;
      end else begin
         test_cnt_reg <= test_cnt_reg + 4'h1;
      end
   end

   // The test clock source is swapped in or out only where both the
   // divided and the test clock have just begun a low phase, so the
   // switch never leaves a short pulse on an output.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         test_ref_reg <= 1'b0;
      end else if (div_cnt_reg == 4'h0 && test_cnt_reg == 4'h0
                   && !test_level_reg) begin
         test_ref_reg <= test_mode_reg & test_sel_reg;
      end
   end

   assign src_level   = div_cnt_reg[1];
   assign bus_level   = (div_cnt_reg >= BUS_HIGH_FROM);
   assign stop_active = ~sw_run_reg;
   assign test_tri    = test_mode_reg & ~test_sel_reg;
   assign test_ref    = test_ref_reg;
   assign src_req     = {7{pd_s}}
                        | ({7{stop_active}} & serial_stop_en_reg);
   assign bus_req     = {9{pd_s}}
                        | ({9{stop_active}}
                           & {fixed_stop_en_reg, 6'h3F});

   cspc_gate #(
      .N (7)
   ) u_src_gate (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .src_level (src_level),
      .stop_req  (src_req),
      .clk_out   (src_out),
      .stopped   (src_stopped)
   );

   cspc_gate #(
      .N (9)
   ) u_bus_gate (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .src_level (bus_level),
      .stop_req  (bus_req),
      .clk_out   (bus_out),
      .stopped   (bus_stopped)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         serial_ref_true  <= 7'h00;
         serial_ref_comp  <= 7'h7F;
         serial_ref_oe    <= 7'h7F;
         fixed_bus_clk    <= 3'h0;
         fixed_bus_oe     <= 3'h7;
         bus_clk          <= 6'h00;
         bus_clk_oe       <= 6'h3F;
         display_96mhz_oe <= 1'b1;
         cpu_pair_oe      <= 2'h3;
         ref_drive_low    <= RST_REF_LOW;
      end else begin
         serial_ref_true <= test_ref ? {7{test_level_reg}} : src_out;
         serial_ref_comp <= test_ref ? {7{~test_level_reg}} : ~src_out;
         serial_ref_oe   <= ~({7{test_tri}}
                              | (src_stopped & {7{stop_active & ~pd_s
                                                  & src_stop_tri_reg}})
                              | {7{pd_s & src_pd_tri_reg}});
         fixed_bus_clk   <= test_ref ? {3{test_level_reg}} : bus_out[8:6];
         fixed_bus_oe    <= ~{3{test_tri}};
         bus_clk         <= test_ref ? {6{test_level_reg}} : bus_out[5:0];
         bus_clk_oe      <= ~{6{test_tri}};
         display_96mhz_oe <= ~(test_tri | (pd_s & dot_pd_tri_reg));
         cpu_pair_oe     <= ~({2{test_tri}}
                              | ({2{pd_s}} & cpu_pd_tri_reg));
         ref_drive_low   <= ref_low_reg;
      end
   end
endmodule

// ==== test/cspc_chk.sv ====
module cspc_chk (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       scl_pin,
   input wire logic       sda_pin_oe,
   input wire logic       power_down_input,
   input wire logic [7:1] serial_ref_true,
   input wire logic [7:1] serial_ref_comp,
   input wire logic [2:0] fixed_bus_clk,
   input wire logic [5:0] bus_clk,
   input wire logic [5:0] bus_clk_oe,
   input wire logic [1:0] cpu_pair_oe,
   input wire logic       ref_drive_low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] pd_cnt;

   // Counts how long power-down has been held, saturating.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pd_cnt <= 5'h00;
      end else if (!power_down_input) begin
         pd_cnt <= 5'h00;
      end else if (pd_cnt != 5'h1F) begin
         pd_cnt <= pd_cnt + 5'h01;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence src_high_s;
      serial_ref_true[1] [*2];
   endsequence
   sequence src_low_s;
      !serial_ref_true[7] [*2];
   endsequence
   sequence bus_high_s;
      bus_clk[0] [*4];
   endsequence

   pair_comp_a: assert property (
      serial_ref_comp == ~serial_ref_true)
      else $error("serial pair halves not complementary");
   ack_edge_a: assert property (
      $changed(sda_pin_oe) |-> !scl_pin)
      else $error("data line changed while serial clock high");
   src_pulse_a: assert property (
      $rose(serial_ref_true[1]) |-> src_high_s)
      else $error("short high pulse on serial pair");
   src_low_a: assert property (
      $fell(serial_ref_true[7]) |-> src_low_s)
      else $error("short low pulse on serial pair");
   bus_pulse_a: assert property (
      $rose(bus_clk[0]) |-> bus_high_s)
      else $error("short high pulse on bus clock");
   fixed_pulse_a: assert property (
      $rose(fixed_bus_clk[2]) |-> fixed_bus_clk[2] [*4])
      else $error("short high pulse on fixed bus clock");
   pd_quiet_a: assert property (
      pd_cnt == 5'h18 |-> bus_clk == 6'h00 && fixed_bus_clk == 3'h0
         && serial_ref_true == 7'h00)
      else $error("clock still running in power-down");
   reset_state_a: assert property (
      $rose(rst_n) |-> ref_drive_low && &cpu_pair_oe && &bus_clk_oe)
      else $error("wrong output state after reset");
endmodule

bind cspc_top cspc_chk cspc_chk_inst (
   .mclk(mclk), .rst_n(rst_n), .scl_pin(scl_pin),
   .sda_pin_oe(sda_pin_oe), .power_down_input(power_down_input),
   .serial_ref_true(serial_ref_true), .serial_ref_comp(serial_ref_comp),
   .fixed_bus_clk(fixed_bus_clk), .bus_clk(bus_clk),
   .bus_clk_oe(bus_clk_oe), .cpu_pair_oe(cpu_pair_oe),
   .ref_drive_low(ref_drive_low)
);

// ==== test/cspc_host.sv ====
module cspc_host
   import cspc_pkg::*;
(
   input  wire logic mclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 10;

   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   task automatic tk();
      repeat (Q) @(negedge mclk);
   endtask

   // Data moves a quarter bit after the clock falls; read at mid-high.
   task automatic bitx(input logic b, output logic r);
      sda_oe = !b;
      tk();
      scl = 1'b1;
      tk();
      r = sda_line;
      tk();
      scl = 1'b0;
      tk();
   endtask

   task automatic start();
      sda_oe = 1'b0;
      tk();
      scl = 1'b1;
      tk();
      sda_oe = 1'b1;
      tk();
      scl = 1'b0;
      tk();
   endtask

   task automatic stop();
      sda_oe = 1'b1;
      tk();
      scl = 1'b1;
      tk();
      sda_oe = 1'b0;
      tk();
   endtask

   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask

   // A single byte is read, so the master answers with a NACK.
   task automatic get(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(1'b1, r);
   endtask

   task automatic wr(input logic [6:0] a, input logic [6:0] ofs,
                     input logic [7:0] d, output logic ok);
      logic [2:0] k;
      start();
      put({a, 1'b0}, k[0]);
      put({1'b1, ofs}, k[1]);
      put(d, k[2]);
      stop();
      ok = &k;
   endtask

   task automatic rd(input logic [6:0] ofs, output logic [7:0] d,
                     output logic ok);
      logic [2:0] k;
      start();
      put({SLAVE_ADDR, 1'b0}, k[0]);
      put({1'b1, ofs}, k[1]);
      start();
      put({SLAVE_ADDR, 1'b1}, k[2]);
      get(d);
      stop();
      ok = &k;
   endtask

   // Block write: count byte, then data from offset 0 upward; only the
   // fourth data byte lands in a register of this block.
   task automatic blk_wr(input logic [7:0] d, output logic ok);
      logic [6:0] k;
      start();
      put({SLAVE_ADDR, 1'b0}, k[0]);
      put(8'h00, k[1]);
      put(8'h04, k[2]);
      for (int i = 0; i < 3; i++) put(8'h00, k[3 + i]);
      put(d, k[6]);
      stop();
      ok = &k;
   endtask
endmodule

// ==== test/cspc_top_bench.sv ====
module cspc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cspc_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        power_down_input = 1'b0;
   logic        power_good_input_n = 1'b1;
   logic [4:0]  strap = 5'h15;
   logic        scl_pin;
   logic        host_oe;
   logic        sda_pin_in;
   logic        sda_pin_out;
   logic        sda_pin_oe;
   logic [7:1]  serial_ref_true;
   logic [7:1]  serial_ref_comp;
   logic [7:1]  serial_ref_oe;
   logic [2:0]  fixed_bus_clk;
   logic [2:0]  fixed_bus_oe;
   logic [5:0]  bus_clk;
   logic [5:0]  bus_clk_oe;
   logic        display_96mhz_oe;
   logic [1:0]  cpu_pair_oe;
   logic        ref_drive_low;
   logic [15:0] tg;
   int          error_cnt = 0;
   int          n_compared = 0;

   always #5 mclk = ~mclk;
   // Open-drain data line with a pull-up.
   assign sda_pin_in = !(host_oe || sda_pin_oe);

   cspc_top cspc_top_inst (
      .mclk(mclk), .rst_n(rst_n), .scl_pin(scl_pin),
      .sda_pin_in(sda_pin_in), .sda_pin_out(sda_pin_out),
      .sda_pin_oe(sda_pin_oe), .freq_strap_first(strap[0]),
      .freq_strap_second(strap[1]), .freq_strap_third(strap[2]),
      .freq_strap_fourth(strap[3]), .freq_strap_fifth(strap[4]),
      .power_good_input_n(power_good_input_n),
      .power_down_input(power_down_input),
      .serial_ref_true(serial_ref_true), .serial_ref_comp(serial_ref_comp),
      .serial_ref_oe(serial_ref_oe), .fixed_bus_clk(fixed_bus_clk),
      .fixed_bus_oe(fixed_bus_oe), .bus_clk(bus_clk),
      .bus_clk_oe(bus_clk_oe), .display_96mhz_oe(display_96mhz_oe),
      .cpu_pair_oe(cpu_pair_oe), .ref_drive_low(ref_drive_low)
   );

   cspc_host cspc_host_inst (
      .mclk(mclk), .sda_line(sda_pin_in), .scl(scl_pin), .sda_oe(host_oe)
   );

   task tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task chk(input string what, input logic [15:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task wr_reg(input logic [6:0] ofs, input logic [7:0] d);
      logic ok;
      cspc_host_inst.wr(SLAVE_ADDR, ofs, d, ok);
      chk("write ack", 16'h0001, {15'h0000, ok});
   endtask

   task rd_reg(input logic [6:0] ofs, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      cspc_host_inst.rd(ofs, d, ok);
      chk("read ack", 16'h0001, {15'h0000, ok});
      chk("read data", {8'h00, e}, {8'h00, d});
   endtask

   // Records which clock outputs toggled over 30 cycles after settling.
   task watch();
      logic [15:0] p;
      tg = 16'h0000;
      repeat (30) @(negedge mclk);
      p = {serial_ref_true, fixed_bus_clk, bus_clk};
      repeat (30) begin
         @(negedge mclk);
         tg = tg | (p ^ {serial_ref_true, fixed_bus_clk, bus_clk});
         p = {serial_ref_true, fixed_bus_clk, bus_clk};
      end
   endtask

   task t_reset();
      rd_reg(OFS_SERIAL_STOP, 8'h00);
      rd_reg(OFS_STRAP_FIXED, {strap[4], 7'h07});
      rd_reg(OFS_DRIVE_MODE, 8'h00);
      rd_reg(OFS_TEST_STOP, {2'b00, strap[3], 2'b11, strap[2:0]});
      chk("ref drive", 16'h0001, {15'h0000, ref_drive_low});
      chk("sda out", 16'h0000, {15'h0000, sda_pin_out});
      watch();
      chk("toggles", 16'hFFFF, tg);
   endtask

   task t_rw();
      logic ok;
      wr_reg(OFS_SERIAL_STOP, 8'hFE);
      rd_reg(OFS_SERIAL_STOP, 8'hFE);
      wr_reg(OFS_STRAP_FIXED, 8'h7F);
      rd_reg(OFS_STRAP_FIXED, {strap[4], 7'h7F});
      wr_reg(OFS_DRIVE_MODE, 8'h8B);
      rd_reg(OFS_DRIVE_MODE, 8'h8B);
      wr_reg(OFS_TEST_STOP, 8'h2A);
      rd_reg(OFS_TEST_STOP, {2'b00, strap[3], 2'b01, strap[2:0]});
      chk("ref drive", 16'h0000, {15'h0000, ref_drive_low});
      wr_reg(7'h10, 8'h55);
      rd_reg(7'h10, 8'h00);
      cspc_host_inst.wr(SLAVE_ADDR ^ 7'h01, OFS_SERIAL_STOP, 8'h00, ok);
      chk("foreign ack", 16'h0000, {15'h0000, ok});
      rd_reg(OFS_SERIAL_STOP, 8'hFE);
      cspc_host_inst.blk_wr(8'h54, ok);
      chk("block ack", 16'h0001, {15'h0000, ok});
      rd_reg(OFS_SERIAL_STOP, 8'h54);
   endtask

   task t_stop();
      wr_reg(OFS_SERIAL_STOP, 8'hAA);
      wr_reg(OFS_STRAP_FIXED, 8'h27);
      wr_reg(OFS_DRIVE_MODE, 8'h80);
      wr_reg(OFS_TEST_STOP, 8'h10);
      watch();
      chk("toggles", {7'h2A, 3'h3, 6'h00}, tg);
      chk("serial oe", 16'h002A, {9'h000, serial_ref_oe});
      wr_reg(OFS_TEST_STOP, 8'h18);
      watch();
      chk("toggles", 16'hFFFF, tg);
      chk("serial oe", 16'h007F, {9'h000, serial_ref_oe});
   endtask

   task t_pd();
      wr_reg(OFS_STRAP_FIXED, 8'h47);
      wr_reg(OFS_DRIVE_MODE, 8'h0A);
      power_down_input = 1'b1;
      watch();
      chk("toggles", 16'h0000, tg);
      chk("pd oe", 16'h0002,
          {6'h00, serial_ref_oe, cpu_pair_oe, display_96mhz_oe});
      power_down_input = 1'b0;
      watch();
      chk("toggles", 16'hFFFF, tg);
      chk("pd oe", 16'h03FF,
          {6'h00, serial_ref_oe, cpu_pair_oe, display_96mhz_oe});
   endtask

   task t_test();
      wr_reg(OFS_TEST_STOP, 8'h58);
      watch();
      chk("test oe", 16'h0000,
          {serial_ref_oe, fixed_bus_oe, bus_clk_oe});
      wr_reg(OFS_TEST_STOP, 8'hD8);
      watch();
      chk("toggles", 16'hFFFF, tg);
      chk("test oe", 16'hFFFF,
          {serial_ref_oe, fixed_bus_oe, bus_clk_oe});
      wr_reg(OFS_TEST_STOP, 8'h18);
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      repeat (6) @(negedge mclk);
      power_good_input_n = 1'b0;
      repeat (10) @(negedge mclk);
      t_reset();
      t_rw();
      t_stop();
      t_pd();
      t_test();
      tally_and_finish();
   end
endmodule
